// >>> src/bss_top.v
// Boot source selector: fuse/strap decode, boot ROM and reset vector
`timescale 1ns/100ps
`default_nettype none
`include "bss_defs.vh"

module bss_top (
  // Clock and reset
  input  wire                   mclk_i,
  input  wire                   rst_i,
  // Fuse and strap inputs
  input  wire [3:0]             boot_source_code_i,
  input  wire                   fuse_blank_i,
  input  wire [3:0]             strap_pins_i,
  // In-system load request from loader software
  input  wire                   in_system_load_i,
  input  wire                   sram_load_done_i,
  // Core instruction fetch port
  input  wire                   fetch_req_i,
  input  wire [31:0]            fetch_addr_i,
  output wire                   fetch_rom_hit_o,
  output wire                   fetch_ack_o,
  output wire [31:0]            fetch_data_o,
  // Boot decision
  output reg                    boot_ready_o,
  output reg  [3:0]             boot_code_o,
  output reg  [`BSS_SEL_W-1:0]  boot_sel_o,
  output reg                    from_straps_o,
  output reg                    reserved_code_o,
  output reg  [31:0]            reset_vector_o,
  output reg                    run_from_sram_o,
  // Pin mux control
  output reg  [2:0]             qspi_pin_fn_o,
  output reg  [2:0]             ser_pin_fn_o,
  output reg  [2:0]             par_pin_fn_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_SYNC   = 4'b0001;
  localparam ST_DECIDE = 4'b0010;
  localparam ST_BOOT   = 4'b0100;
  localparam ST_SRAM   = 4'b1000;

  reg  [3:0]            state_r;
  reg  [3:0]            state_nxt;
  reg  [1:0]            wait_r;
  wire [3:0]            fuse_s;
  wire [3:0]            strap_s;
  wire [0:0]            blank_s;
  reg  [3:0]            strap_r;
  reg  [3:0]            code_nxt;
  reg                   from_straps_nxt;
  reg                   rsv_nxt;
  reg  [`BSS_SEL_W-1:0] sel_nxt;
  reg                   rd_ack_r;
  wire                  rom_rd;
  reg  [3:0]            strap_code_nxt;
  reg  [2:0]            qspi_fn_nxt;
  reg  [2:0]            ser_fn_nxt;
  reg  [2:0]            par_fn_nxt;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  bss_sync2 #(.W(4)) u_sync_fuse (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (boot_source_code_i),
    .q_o    (fuse_s)
  );

  bss_sync2 #(.W(4)) u_sync_strap (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (strap_pins_i),
    .q_o    (strap_s)
  );

  bss_sync2 #(.W(1)) u_sync_blank (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (fuse_blank_i),
    .q_o    (blank_s)
  );

  // ----------------------------------------
  // Boot ROM
  // ----------------------------------------
  // Only the low 64 kB of the fetch window maps to the ROM
  assign fetch_rom_hit_o = (fetch_addr_i[31:16] == `BSS_ROM_BASE_HI);
  // A miss never reaches the ROM, so it is never acknowledged
  assign rom_rd          = fetch_req_i & fetch_rom_hit_o;

  bss_rom u_rom (
    .mclk_i  (mclk_i),
    .rd_en_i (rom_rd),
    .addr_i  (fetch_addr_i[`BSS_ROM_AW+1:2]),
    .rdata_o (fetch_data_o)
  );

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_ack_r <= 1'b0;
    else
      rd_ack_r <= rom_rd;
  end

  // One-cycle acknowledge; read data stands until the next accepted read
  assign fetch_ack_o = rd_ack_r;

  // ----------------------------------------
  // Source decode
  // ----------------------------------------
  // Strap decode is our own: straps carry a boot code directly
  // Straps giving zero or a reserved code would leave no source
  always @*
  begin
    strap_code_nxt = strap_r;
    if ((strap_r == `BSS_CODE_PINS) || (strap_r >= `BSS_CODE_RSV_LO))
      strap_code_nxt = `BSS_SAFE_CODE;
  end

  always @*
  begin
    from_straps_nxt = 1'b0;
    rsv_nxt         = 1'b0;
    code_nxt        = fuse_s;
    if (blank_s[0] || (fuse_s == `BSS_CODE_PINS))
    begin
      from_straps_nxt = 1'b1;
      code_nxt        = strap_code_nxt;
    end
    else if (fuse_s >= `BSS_CODE_RSV_LO)
    begin
      from_straps_nxt = 1'b1;
      rsv_nxt         = 1'b1;
      code_nxt        = strap_code_nxt;
    end
  end

  always @*
  begin
    sel_nxt = {`BSS_SEL_W{1'b0}};
    case (code_nxt)
      `BSS_CODE_SER0:   sel_nxt[`BSS_SEL_SER0]   = 1'b1;
      `BSS_CODE_QFLASH: sel_nxt[`BSS_SEL_QFLASH] = 1'b1;
      `BSS_CODE_PAR8:   sel_nxt[`BSS_SEL_PAR8]   = 1'b1;
      `BSS_CODE_PAR16:  sel_nxt[`BSS_SEL_PAR16]  = 1'b1;
      `BSS_CODE_PAR32:  sel_nxt[`BSS_SEL_PAR32]  = 1'b1;
      `BSS_CODE_USB_PORT_ZERO:   sel_nxt[`BSS_SEL_USB_PORT_ZERO]   = 1'b1;
      `BSS_CODE_USB_PORT_ONE:   sel_nxt[`BSS_SEL_USB_PORT_ONE]   = 1'b1;
      `BSS_CODE_SPI0:   sel_nxt[`BSS_SEL_SPI0]   = 1'b1;
      `BSS_CODE_SER3:   sel_nxt[`BSS_SEL_SER3]   = 1'b1;
      default:          sel_nxt[`BSS_SEL_SER0]   = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Pin function decode
  // ----------------------------------------
  // Flash port pins carry different functions for quad flash and for SPI
  always @*
  begin
    qspi_fn_nxt = `BSS_FN_GPIO;
    ser_fn_nxt  = `BSS_FN_GPIO;
    par_fn_nxt  = `BSS_FN_GPIO;
    if (sel_nxt[`BSS_SEL_QFLASH])
    begin
      qspi_fn_nxt = `BSS_FN_QF;
    end
    else if (sel_nxt[`BSS_SEL_SPI0])
    begin
      qspi_fn_nxt = `BSS_FN_SPI;
    end
    // Serial zero and serial three share the serial pin function
    if (sel_nxt[`BSS_SEL_SER0] || sel_nxt[`BSS_SEL_SER3])
    begin
      ser_fn_nxt = `BSS_FN_SER;
    end
    // All three bus widths share chip select zero
    if (sel_nxt[`BSS_SEL_PAR8] || sel_nxt[`BSS_SEL_PAR16] || sel_nxt[`BSS_SEL_PAR32])
    begin
      par_fn_nxt = `BSS_FN_PAR;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_SYNC:
      begin
        if (wait_r == `BSS_SYNC_WAIT)
          state_nxt = ST_DECIDE;
      end
      ST_DECIDE:
      begin
        state_nxt = ST_BOOT;
      end
      ST_BOOT:
      begin
        // Load path only exists over serial port zero
        if (in_system_load_i && sram_load_done_i && boot_sel_o[`BSS_SEL_SER0])
          state_nxt = ST_SRAM;
      end
      ST_SRAM:
      begin
        state_nxt = ST_SRAM;
      end
      default:
      begin
        state_nxt = ST_SYNC;
      end
    endcase
  end

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      state_r <= ST_SYNC;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------
  // Synchroniser settling and strap capture
  // ----------------------------------------
  // Counts the settling edges of the input synchronisers
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      wait_r <= 2'h0;
    else if (state_r == ST_SYNC)
      wait_r <= wait_r + 2'h1;
  end

  // Sampled once after the synchronisers settle, then frozen
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      strap_r <= 4'h0;
    else if ((state_r == ST_SYNC) && (wait_r == `BSS_SYNC_WAIT))
      strap_r <= strap_s;
  end

  // ----------------------------------------
  // Decision outputs and pin mux
  // ----------------------------------------
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot_ready_o    <= 1'b0;
      boot_code_o     <= 4'h0;
      boot_sel_o      <= {`BSS_SEL_W{1'b0}};
      from_straps_o   <= 1'b0;
      reserved_code_o <= 1'b0;
      reset_vector_o  <= `BSS_ROM_BASE;
      qspi_pin_fn_o   <= `BSS_FN_GPIO;
      ser_pin_fn_o    <= `BSS_FN_GPIO;
      par_pin_fn_o    <= `BSS_FN_GPIO;
    end
    else if (state_r == ST_DECIDE)
    begin
      boot_ready_o    <= 1'b1;
      boot_code_o     <= code_nxt;
      boot_sel_o      <= sel_nxt;
      from_straps_o   <= from_straps_nxt;
      reserved_code_o <= rsv_nxt;
      qspi_pin_fn_o   <= qspi_fn_nxt;
      ser_pin_fn_o    <= ser_fn_nxt;
      par_pin_fn_o    <= par_fn_nxt;
    end
  end

  // ----------------------------------------
  // Load state
  // ----------------------------------------
  // Sticky until reset: the core stays on the loaded image
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      run_from_sram_o <= 1'b0;
    else if (state_nxt == ST_SRAM)
      run_from_sram_o <= 1'b1;
  end

endmodule // bss_top

`default_nettype wire

// >>> src/bss_defs.vh
// Constants for the boot source selector
`ifndef BSS_DEFS_VH
`define BSS_DEFS_VH

// ----------------------------------------
// Boot source codes
// ----------------------------------------
`define BSS_CODE_PINS      4'h0
`define BSS_CODE_SER0      4'h1
`define BSS_CODE_QFLASH    4'h2
`define BSS_CODE_PAR8      4'h3
`define BSS_CODE_PAR16     4'h4
`define BSS_CODE_PAR32     4'h5
`define BSS_CODE_USB_PORT_ZERO      4'h6
`define BSS_CODE_USB_PORT_ONE      4'h7
`define BSS_CODE_SPI0      4'h8
`define BSS_CODE_SER3      4'h9
`define BSS_CODE_RSV_LO    4'ha

// ----------------------------------------
// One-hot source select bit positions
// ----------------------------------------
`define BSS_SEL_W          9
`define BSS_SEL_SER0       0
`define BSS_SEL_QFLASH     1
`define BSS_SEL_PAR8       2
`define BSS_SEL_PAR16      3
`define BSS_SEL_PAR32      4
`define BSS_SEL_USB_PORT_ZERO       5
`define BSS_SEL_USB_PORT_ONE       6
`define BSS_SEL_SPI0       7
`define BSS_SEL_SER3       8

// ----------------------------------------
// Boot ROM geometry: 64 kB, 32-bit words
// ----------------------------------------
`define BSS_ROM_BYTES      65536
`define BSS_ROM_AW         14
`define BSS_ROM_BASE       32'h0000_0000
`define BSS_ROM_BASE_HI    16'h0000

// ----------------------------------------
// Pin function codes driven to the pin mux
// ----------------------------------------
`define BSS_FN_GPIO        3'h0
`define BSS_FN_QF          3'h1
`define BSS_FN_SPI         3'h2
`define BSS_FN_SER         3'h3
`define BSS_FN_PAR         3'h4

// Default strap-pin fallback when straps give no source
`define BSS_SAFE_CODE      4'h1
`define BSS_FUSE_BLANK     4'h0

// Synchroniser settling count before the straps are captured
`define BSS_SYNC_WAIT      2'h2

`endif

// >>> src/bss_sync2.v
// Two-stage synchroniser for strap and fuse inputs
`timescale 1ns/100ps
`default_nettype none

module bss_sync2 #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         mclk_i,
  input  wire         rst_i,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule // bss_sync2

`default_nettype wire

// >>> src/bss_rom.v
// Boot ROM store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "bss_defs.vh"

module bss_rom (
  // Clock
  input  wire                    mclk_i,
  // Read port
  input  wire                    rd_en_i,
  input  wire [`BSS_ROM_AW-1:0]  addr_i,
  output reg  [31:0]             rdata_o
);

  // Loader image contents are filled by the mask step; blank in RTL
  reg [31:0] mem_r [0:(1<<`BSS_ROM_AW)-1];
  integer    i;

  initial
  begin
    for (i = 0; i < (1 << `BSS_ROM_AW); i = i + 1)
      mem_r[i] = 32'h0000_0000;
  end

  always @(posedge mclk_i)
  begin
    if (rd_en_i)
      rdata_o <= mem_r[addr_i];
  end

endmodule // bss_rom

`default_nettype wire

// >>> tb/bss_monitor.sv
// Port checker for the boot source selector
`timescale 1ns/100ps
`default_nettype none
`include "bss_defs.vh"
module bss_monitor (
  // Clock and reset
  input wire logic                  mclk_i,
  input wire logic                  rst_i,
  // Watched ports
  input wire logic                  fetch_req_i,
  input wire logic [31:0]           fetch_addr_i,
  input wire logic                  fetch_rom_hit_o,
  input wire logic                  fetch_ack_o,
  input wire logic                  boot_ready_o,
  input wire logic [3:0]            boot_code_o,
  input wire logic [`BSS_SEL_W-1:0] boot_sel_o,
  input wire logic                  from_straps_o,
  input wire logic                  reserved_code_o,
  input wire logic [31:0]           reset_vector_o,
  input wire logic                  run_from_sram_o,
  input wire logic [2:0]            qspi_pin_fn_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_ack; fetch_req_i && fetch_rom_hit_o |=> fetch_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("hit not acked");
  property p_noack; !(fetch_req_i && fetch_rom_hit_o) |=> !fetch_ack_o; endproperty
  a_noack: assert property (p_noack) else $error("stray ack");
  property p_hit; fetch_rom_hit_o == (fetch_addr_i[31:16] == 16'h0); endproperty
  a_hit: assert property (p_hit) else $error("rom window wrong");
  property p_vec; boot_ready_o |-> reset_vector_o == 32'h0; endproperty
  a_vec: assert property (p_vec) else $error("vector not rom base");
  property p_sel; boot_ready_o |-> boot_sel_o == (9'h001 << (boot_code_o - 4'h1)); endproperty
  a_sel: assert property (p_sel) else $error("select mismatches code");
  property p_hold; boot_ready_o |=> boot_ready_o && $stable(boot_sel_o); endproperty
  a_hold: assert property (p_hold) else $error("decision moved");
  property p_qf;
    boot_ready_o |-> qspi_pin_fn_o == (boot_sel_o[1] ? 3'h1 : boot_sel_o[7] ? 3'h2 : 3'h0);
  endproperty
  a_qf: assert property (p_qf) else $error("flash pin mux wrong");
  property p_sram; run_from_sram_o |-> boot_sel_o[0]; endproperty
  a_sram: assert property (p_sram) else $error("sram run off serial");
  property p_rsv; reserved_code_o |-> from_straps_o && boot_ready_o; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved not deferred");
endmodule // bss_monitor

bind bss_top bss_monitor bss_monitor_inst (.mclk_i, .rst_i, .fetch_req_i, .fetch_addr_i,
  .fetch_rom_hit_o, .fetch_ack_o, .boot_ready_o, .boot_code_o, .boot_sel_o, .from_straps_o,
  .reserved_code_o, .reset_vector_o, .run_from_sram_o, .qspi_pin_fn_o);
`default_nettype wire

// >>> tb/bss_host.sv
// Serial host model that pushes an image for in-system load
`timescale 1ns/100ps
`default_nettype none
module bss_host (
  // Clock and control
  input  wire logic mclk_i,
  input  wire logic start_i,
  // Loader handshake
  output var logic  in_system_load_o,
  output var logic  load_done_o
);
  int cnt = 0;
  initial in_system_load_o = 1'b0;
  initial load_done_o = 1'b0;
  // Image takes a few cycles on the wire before done
  always @(negedge mclk_i)
  begin
    in_system_load_o <= start_i;
    cnt <= start_i ? cnt + 1 : 0;
    load_done_o <= start_i && cnt >= 3;
  end
endmodule // bss_host
`default_nettype wire

// >>> tb/tb.sv
// Testbench for the boot source selector
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  code = 4'h0;
  logic        blank = 1'b0;
  logic [3:0]  strap = 4'h0;
  logic        req = 1'b0;
  logic [31:0] addr = 32'h0;
  logic        go = 1'b0;
  wire logic   isl, done, hit, ack, rdy, strp, rsv, sram;
  wire logic [31:0] data, vec;
  wire logic [3:0]  bcode;
  wire logic [8:0]  sel;
  wire logic [2:0]  qf, sf, pf;
  int mismatches = 0;
  int samples_checked = 0;
  always #10 mclk_i = ~mclk_i;
  bss_host bss_host_inst (.mclk_i(mclk_i), .start_i(go), .in_system_load_o(isl),
    .load_done_o(done));
  bss_top bss_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .boot_source_code_i(code),
    .fuse_blank_i(blank), .strap_pins_i(strap), .in_system_load_i(isl),
    .sram_load_done_i(done), .fetch_req_i(req), .fetch_addr_i(addr),
    .fetch_rom_hit_o(hit), .fetch_ack_o(ack), .fetch_data_o(data), .boot_ready_o(rdy),
    .boot_code_o(bcode), .boot_sel_o(sel), .from_straps_o(strp), .reserved_code_o(rsv),
    .reset_vector_o(vec), .run_from_sram_o(sram), .qspi_pin_fn_o(qf), .ser_pin_fn_o(sf),
    .par_pin_fn_o(pf));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic boot(input logic [3:0] c, input logic b, input logic [3:0] s);
    @(negedge mclk_i);
    rst_i = 1'b1;
    code = c;
    blank = b;
    strap = s;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge mclk_i);
  endtask
  task automatic dec(input logic [3:0] e, input logic st, input logic rv);
    chk(rdy, 1);
    chk(bcode, e);
    chk(sel, 32'h1 << (e - 4'h1));
    chk(strp, st);
    chk(rsv, rv);
    chk(qf, e == 4'h2 ? 1 : e == 4'h8 ? 2 : 0);
    chk(sf, (e == 4'h1 || e == 4'h9) ? 3 : 0);
    chk(pf, (e >= 4'h3 && e <= 4'h5) ? 4 : 0);
    chk(vec, 0);
  endtask
  task automatic t_fuse;
    for (int e = 1; e < 10; e++)
    begin
      boot(e[3:0], 1'b0, 4'h6);
      dec(e[3:0], 1'b0, 1'b0);
    end
  endtask
  task automatic t_straps;
    boot(4'h0, 1'b0, 4'h6);
    dec(4'h6, 1'b1, 1'b0);
    boot(4'h9, 1'b1, 4'h8);
    dec(4'h8, 1'b1, 1'b0);
    boot(4'h0, 1'b0, 4'h0);
    dec(4'h1, 1'b1, 1'b0);
    for (int c = 10; c < 16; c++)
    begin
      boot(c[3:0], 1'b0, 4'h2);
      dec(4'h2, 1'b1, 1'b1);
    end
    strap = 4'h7;
    repeat (5) @(negedge mclk_i);
    dec(4'h2, 1'b1, 1'b1);
  endtask
  task automatic t_fetch;
    boot(4'h3, 1'b0, 4'h0);
    req = 1'b1;
    @(negedge mclk_i);
    chk(ack, 1);
    chk(data, 0);
    addr = 32'h0000_fffc;
    @(negedge mclk_i);
    chk(ack, 1);
    addr = 32'h0001_0000;
    #1 chk(hit, 0);
    @(negedge mclk_i);
    chk(ack, 0);
    req = 1'b0;
    @(negedge mclk_i);
    chk(ack, 0);
  endtask
  task automatic t_load(input logic [3:0] c, input logic exp);
    boot(c, 1'b0, 4'h0);
    go = 1'b1;
    for (int i = 0; i < 10 && sram !== 1'b1; i++) @(negedge mclk_i);
    go = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(sram, exp);
  endtask
  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    t_fuse;
    t_straps;
    t_fetch;
    t_load(4'h1, 1'b1);
    t_load(4'h2, 1'b0);
    stop_test;
  end
endmodule // tb
`default_nettype wire
